// ===== logic/ums_top.sv
// Modem status inputs of two serial ports behind an AXI4-Lite slave.
// Assumes one 125 MHz clock and a synchronous active-low reset.
//
// Behaviour
// - Two ports, separate lines, handled independently
// - Status bit 5 is inverted set-ready level
// - Set-ready rising edge sets bit 1
// - Status bit 7 is inverted carrier level
// - Carrier rising edge sets bit 3
// - Status bit 6 is inverted ring level
// - Ring rising edge sets bit 2
// - Enable bit 3 lets line changes interrupt
// - Status bit 4 is inverted clear-send level
// - Clear-send rising edge sets bit 0
// - Clear-send only status, never gates transmit
module ums_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port 0 modem lines
  input  wire logic        port0_set_ready_n,
  input  wire logic        port0_carrier_n,
  input  wire logic        port0_ring_n,
  input  wire logic        port0_clear_send_n,
  // Port 1 modem lines
  input  wire logic        port1_set_ready_n,
  input  wire logic        port1_carrier_n,
  input  wire logic        port1_ring_n,
  input  wire logic        port1_clear_send_n,
  // Interrupts
  output logic [1:0]       port_int,
  output logic             irq
);
  localparam int unsigned NP = ums_pkg::NUM_PORTS;

  // Address decode shared by both channels
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    logic [2:0] s;
    s = ums_pkg::REG_NONE;
    case (a[ums_pkg::ADDR_W-1:0])
      ums_pkg::OFS_MSR0: s = ums_pkg::REG_MSR0;
      ums_pkg::OFS_MSR1: s = ums_pkg::REG_MSR1;
      ums_pkg::OFS_IER0: s = ums_pkg::REG_IER0;
      ums_pkg::OFS_IER1: s = ums_pkg::REG_IER1;
      ums_pkg::OFS_STAT: s = ums_pkg::REG_STAT;
      ums_pkg::OFS_MASK: s = ums_pkg::REG_MASK;
      default:           s = ums_pkg::REG_NONE;
    endcase
    return s;
  endfunction

  ums_pkg::ums_lines_t lines_n [NP];
  logic [7:0]          modem_status_reg [NP];
  logic [NP-1:0]       chg;
  logic [NP-1:0]       rd_clr;

  // Write channel state
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        wr_fire, aw_hs, w_hs;
  logic [2:0]  wsel;

  // Read channel state
  logic        r_q, r_d, ar_hs;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [2:0]  rsel;

  // Software registers
  logic [7:0]    ier_q [NP];
  logic [7:0]    ier_d [NP];
  logic [NP-1:0] stat_q, stat_d, mask_q, mask_d;
  logic          wen_b0;

  // Pack each port's pins, identical lane order
  assign lines_n[0] = {port0_carrier_n, port0_ring_n, port0_set_ready_n, port0_clear_send_n};
  assign lines_n[1] = {port1_carrier_n, port1_ring_n, port1_set_ready_n, port1_clear_send_n};

  // One status block per port, read clear per port
  for (genvar p = 0; p < NP; p++) begin : g_port
    ums_port u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .lines_n (lines_n[p]),
      .rd_clr  (rd_clr[p]),
      .modem_status_reg (modem_status_reg[p]),
      .chg     (chg[p])
    );
    assign rd_clr[p]   = ar_hs && (rsel == ums_pkg::REG_MSR0 + 3'(p));
    assign port_int[p] = ier_q[p][ums_pkg::IER_MSI] && (|modem_status_reg[p][3:0]);
  end
  // Clear-send feeds only status and interrupt paths

  // Handshake outputs
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_arready = !r_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wsel          = reg_sel(awaddr_q);
  assign rsel          = reg_sel(s_axi_araddr);

  // Write channel: take address and data in any order
  always_comb begin
    aw_d     = aw_q;
    w_d      = w_q;
    b_d      = b_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bresp_d  = bresp_q;
    wr_fire  = 1'b0;
    if (aw_hs) begin
      aw_d     = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (w_hs) begin
      w_d     = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (aw_q && w_q && !b_q) begin
      wr_fire = 1'b1;
      aw_d    = 1'b0;
      w_d     = 1'b0;
      b_d     = 1'b1;
      bresp_d = (wsel == ums_pkg::REG_NONE) ? ums_pkg::RESP_SLVERR : ums_pkg::RESP_OKAY;
    end
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      b_q      <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bresp_q  <= ums_pkg::RESP_OKAY;
    end else begin
      aw_q     <= aw_d;
      w_q      <= w_d;
      b_q      <= b_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bresp_q  <= bresp_d;
    end
  end

  // Enables, mask, sticky status with set over clear
  always_comb begin
    wen_b0 = wr_fire && wstrb_q[0];
    mask_d = (wen_b0 && wsel == ums_pkg::REG_MASK) ? wdata_q[NP-1:0] : mask_q;
    stat_d = stat_q;
    if (wen_b0 && wsel == ums_pkg::REG_STAT) begin
      stat_d = stat_q & ~wdata_q[NP-1:0];
    end
    for (int p = 0; p < NP; p++) begin
      ier_d[p] = (wen_b0 && wsel == ums_pkg::REG_IER0 + 3'(p)) ? wdata_q[7:0] : ier_q[p];
      if (chg[p] && ier_q[p][ums_pkg::IER_MSI]) begin
        stat_d[p] = 1'b1;
      end
    end
  end

  // Software register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= ums_pkg::MASK_RST;
      stat_q <= ums_pkg::STAT_RST;
      for (int p = 0; p < NP; p++) begin
        ier_q[p] <= ums_pkg::IER_RST;
      end
    end else begin
      mask_q <= mask_d;
      stat_q <= stat_d;
      for (int p = 0; p < NP; p++) begin
        ier_q[p] <= ier_d[p];
      end
    end
  end

  // Read channel: data sampled before the flags clear
  always_comb begin
    r_d     = r_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
    if (ar_hs) begin
      r_d     = 1'b1;
      rresp_d = ums_pkg::RESP_OKAY;
      case (rsel)
        ums_pkg::REG_MSR0: rdata_d = {24'h0, modem_status_reg[0]};
        ums_pkg::REG_MSR1: rdata_d = {24'h0, modem_status_reg[1]};
        ums_pkg::REG_IER0: rdata_d = {24'h0, ier_q[0]};
        ums_pkg::REG_IER1: rdata_d = {24'h0, ier_q[1]};
        ums_pkg::REG_STAT: rdata_d = {30'h0, stat_q};
        ums_pkg::REG_MASK: rdata_d = {30'h0, mask_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = ums_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q     <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= ums_pkg::RESP_OKAY;
    end else begin
      r_q     <= r_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Masked status onto one level output
  assign irq = |(stat_q & mask_q);

  property p_msi_set;
    @(posedge aclk) disable iff (!aresetn) chg[0] && ier_q[0][3] |=> stat_q[0];
  endproperty
  a_msi_set: assert property (p_msi_set) else $error("change did not set status");
  property p_msi_irq;
    @(posedge aclk) disable iff (!aresetn) chg[1] && ier_q[1][3] && mask_q[1] && !wr_fire |=> irq;
  endproperty
  a_msi_irq: assert property (p_msi_irq) else $error("unmasked change gave no irq");
  property p_msi_off;
    @(posedge aclk) disable iff (!aresetn) !ier_q[0][3] && !wr_fire |=> $stable(stat_q[0]) || !stat_q[0];
  endproperty
  a_msi_off: assert property (p_msi_off) else $error("status set while disabled");
  property p_indep;
    @(posedge aclk) disable iff (!aresetn) (|modem_status_reg[1][3:0]) && !rd_clr[1] |=> |modem_status_reg[1][3:0];
  endproperty
  a_indep: assert property (p_indep) else $error("port 1 flags lost");
  property p_int_drop;
    @(posedge aclk) disable iff (!aresetn) rd_clr[0] && !chg[0] |=> !port_int[0];
  endproperty
  a_int_drop: assert property (p_int_drop) else $error("port interrupt stayed after read");
  property p_bhold;
    @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_rlat;
    @(posedge aclk) disable iff (!aresetn) ar_hs |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule

// ===== shared/ums_pkg.sv
// Package for the modem status input block: offsets, fields, reset values.
// Assumes one clock and a synchronous active-low reset.
package ums_pkg;
  // Port count and bus widths
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned ADDR_W    = 8;

  // Register indices, byte address is four times the index
  localparam logic [2:0] REG_MSR0 = 3'h0;
  localparam logic [2:0] REG_MSR1 = 3'h1;
  localparam logic [2:0] REG_IER0 = 3'h2;
  localparam logic [2:0] REG_IER1 = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam logic [2:0] REG_MASK = 3'h5;
  localparam logic [2:0] REG_NONE = 3'h7;

  // Byte offsets
  localparam logic [7:0] OFS_MSR0 = 8'h00;
  localparam logic [7:0] OFS_MSR1 = 8'h04;
  localparam logic [7:0] OFS_IER0 = 8'h08;
  localparam logic [7:0] OFS_IER1 = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  // Line positions: change flag at BIT, level at BIT plus LVL_OFS
  localparam int unsigned BIT_CTS = 0;
  localparam int unsigned BIT_DSR = 1;
  localparam int unsigned BIT_RI  = 2;
  localparam int unsigned BIT_DCD = 3;
  localparam int unsigned LVL_OFS = 4;
  localparam int unsigned IER_MSI = 3;

  // Synchroniser depth seen at the register
  localparam int unsigned SYNC_DEPTH = 3;

  // Reset values
  localparam logic [3:0] LINES_RST = 4'hF;
  localparam logic [7:0] IER_RST   = 8'h00;
  localparam logic [1:0] MASK_RST  = 2'h0;
  localparam logic [1:0] STAT_RST  = 2'h0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Active-low modem lines of one port, in flag bit order
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ums_lines_t;
endpackage

// ===== logic/ums_port.sv
// One port's modem status: synchroniser, edge flags, status byte.
// Assumes rd_clr pulses one cycle when software reads the status byte.
module ums_port (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Modem lines, active low
  input  wire ums_pkg::ums_lines_t lines_n,
  // Register side
  input  wire logic              rd_clr,
  output logic [7:0]             modem_status_reg,
  output logic                   chg
);
  logic [3:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic [3:0] dl_q, dl_d, rise;

  // Sync chain, rising edge of each input, sticky flags
  always_comb begin
    s1_d = lines_n;
    s2_d = s1_q;
    s3_d = s2_q;
    rise = s2_q & ~s3_q;
    dl_d = rd_clr ? 4'h0 : dl_q;
    dl_d = dl_d | rise;
  end

  // Registers, lines idle high at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= ums_pkg::LINES_RST;
      s2_q <= ums_pkg::LINES_RST;
      s3_q <= ums_pkg::LINES_RST;
      dl_q <= 4'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      dl_q <= dl_d;
    end
  end

  // Levels complemented, flags low nibble
  assign modem_status_reg = {~s3_q, dl_q};
  assign chg = |(s2_q ^ s3_q);

  property p_dsr_lvl;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn, 3) |-> modem_status_reg[5] == !$past(lines_n.dsr_n, 3);
  endproperty
  a_dsr_lvl: assert property (p_dsr_lvl) else $error("dsr level bit wrong");
  property p_dcd_lvl;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn, 3) |-> modem_status_reg[7] == !$past(lines_n.dcd_n, 3);
  endproperty
  a_dcd_lvl: assert property (p_dcd_lvl) else $error("dcd level bit wrong");
  property p_ri_lvl;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn, 3) |-> modem_status_reg[6] == !$past(lines_n.ri_n, 3);
  endproperty
  a_ri_lvl: assert property (p_ri_lvl) else $error("ri level bit wrong");
  property p_cts_lvl;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn, 3) |-> modem_status_reg[4] == !$past(lines_n.cts_n, 3);
  endproperty
  a_cts_lvl: assert property (p_cts_lvl) else $error("cts level bit wrong");
  property p_dsr_chg;
    @(posedge aclk) disable iff (!aresetn) $rose(s2_q[1]) |=> modem_status_reg[1];
  endproperty
  a_dsr_chg: assert property (p_dsr_chg) else $error("dsr flag not set");
  property p_dcd_chg;
    @(posedge aclk) disable iff (!aresetn) $rose(s2_q[3]) |=> modem_status_reg[3];
  endproperty
  a_dcd_chg: assert property (p_dcd_chg) else $error("dcd flag not set");
  property p_ri_chg;
    @(posedge aclk) disable iff (!aresetn) $rose(s2_q[2]) |=> modem_status_reg[2];
  endproperty
  a_ri_chg: assert property (p_ri_chg) else $error("ri flag not set");
  property p_cts_chg;
    @(posedge aclk) disable iff (!aresetn) $rose(s2_q[0]) |=> modem_status_reg[0];
  endproperty
  a_cts_chg: assert property (p_cts_chg) else $error("cts flag not set");
  property p_flag_cause;
    @(posedge aclk) disable iff (!aresetn) $rose(modem_status_reg[1]) |-> $past(s2_q[1] && !s3_q[1]);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without edge");
  property p_rd_clear;
    @(posedge aclk) disable iff (!aresetn) rd_clr && !(|rise) |=> modem_status_reg[3:0] == 4'h0;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read");
endmodule

// ===== testbench/ums_modem.sv
// Modem model: drives the active-low handshake lines of both ports.
// Assumes the bench calls set_line from its main sequence, one change at a time.
module ums_modem (
  // Clock
  input  wire logic           aclk,
  // Handshake lines, active low
  output ums_pkg::ums_lines_t port0_lines_n,
  output ums_pkg::ums_lines_t port1_lines_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines start at the inactive high level
  initial begin
    port0_lines_n = ums_pkg::LINES_RST;
    port1_lines_n = ums_pkg::LINES_RST;
  end

  // One line change, launched just after a rising edge
  task automatic set_line(input int p, input int i, input logic v);
    @(posedge aclk);
    if (p == 0) begin
      port0_lines_n[i] <= v;
    end else begin
      port1_lines_n[i] <= v;
    end
  endtask
endmodule

// ===== testbench/tb_ums_top.sv
// Self-checking bench for the modem status block over AXI4-Lite.
// Assumes the modem model drives the lines and a 125 MHz clock.
module tb_ums_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] strb_sel = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, port_int, rsp;
  logic [31:0] rd;
  ums_pkg::ums_lines_t l0_n, l1_n;
  int num_errors = 0, n_checks = 0, cyc = 0;

  ums_modem i_ums_modem (.aclk(aclk), .port0_lines_n(l0_n), .port1_lines_n(l1_n));

  ums_top i_ums_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port0_set_ready_n(l0_n.dsr_n), .port0_carrier_n(l0_n.dcd_n),
    .port0_ring_n(l0_n.ri_n), .port0_clear_send_n(l0_n.cts_n),
    .port1_set_ready_n(l1_n.dsr_n), .port1_carrier_n(l1_n.dcd_n),
    .port1_ring_n(l1_n.ri_n), .port1_clear_send_n(l1_n.cts_n),
    .port_int(port_int), .irq(irq)
  );

  // Clock and hang guard
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Interrupt pins, looked at mid-cycle
  task automatic pins(input logic [1:0] pi, input logic ir);
    @(negedge aclk);
    check({29'h0, port_int, irq}, {29'h0, pi, ir});
  endtask

  // Let a line change pass the synchroniser
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask

  // Bus write: address and data together, wait for response
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go, w_go, b_go;
    b_go = 1'b0;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= strb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_go) begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) bready <= 1'b0;
    end
  endtask

  // Bus read: address, then wait for data
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go, r_go;
    r_go = 1'b0;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_go) begin
      @(negedge aclk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
      if (r_go) rready <= 1'b0;
    end
  endtask

  // Read and compare data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_read(a, rd, rsp);
    check(rd, exp);
    check({30'h0, rsp}, {30'h0, er});
  endtask

  // Reset values, read-write storage, unmapped place
  task automatic t_regs();
    rd_chk(ums_pkg::OFS_MSR0, 32'h0, ums_pkg::RESP_OKAY);
    rd_chk(ums_pkg::OFS_MSR1, 32'h0, ums_pkg::RESP_OKAY);
    rd_chk(ums_pkg::OFS_IER0, 32'h0, ums_pkg::RESP_OKAY);
    rd_chk(ums_pkg::OFS_STAT, 32'h0, ums_pkg::RESP_OKAY);
    rd_chk(ums_pkg::OFS_MASK, 32'h0, ums_pkg::RESP_OKAY);
    rd_chk(8'h18, 32'h0, ums_pkg::RESP_SLVERR);
    axi_write(8'h18, 32'hFF, rsp);
    check({30'h0, rsp}, {30'h0, ums_pkg::RESP_SLVERR});
    axi_write(ums_pkg::OFS_IER1, 32'hA5, rsp);
    check({30'h0, rsp}, {30'h0, ums_pkg::RESP_OKAY});
    rd_chk(ums_pkg::OFS_IER1, 32'hA5, ums_pkg::RESP_OKAY);
    // Lane 0 strobe low leaves the register alone
    strb_sel = 4'hE;
    axi_write(ums_pkg::OFS_IER1, 32'h5A, rsp);
    strb_sel = 4'hF;
    check({30'h0, rsp}, {30'h0, ums_pkg::RESP_OKAY});
    rd_chk(ums_pkg::OFS_IER1, 32'hA5, ums_pkg::RESP_OKAY);
    pins(2'b00, 1'b0);
  endtask

  // Every line of both ports: level, rising flag, clear on read
  task automatic t_lines();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        i_ums_modem.set_line(p, i, 1'b0);
        settle();
        rd_chk(8'(4 * p), 32'h1 << (i + 4), ums_pkg::RESP_OKAY);
        i_ums_modem.set_line(p, i, 1'b1);
        settle();
        rd_chk(8'(4 * p), 32'h1 << i, ums_pkg::RESP_OKAY);
        rd_chk(8'(4 * p), 32'h0, ums_pkg::RESP_OKAY);
        rd_chk(8'(4 - 4 * p), 32'h0, ums_pkg::RESP_OKAY);
      end
    end
  endtask

  // Enable, sticky status, mask, clear by read and by writing ones
  task automatic t_irq();
    axi_write(ums_pkg::OFS_IER0, 32'h08, rsp);
    axi_write(ums_pkg::OFS_IER1, 32'h00, rsp);
    axi_write(ums_pkg::OFS_MASK, 32'h01, rsp);
    i_ums_modem.set_line(0, 2, 1'b0);
    settle();
    rd_chk(ums_pkg::OFS_STAT, 32'h1, ums_pkg::RESP_OKAY);
    pins(2'b00, 1'b1);
    axi_write(ums_pkg::OFS_STAT, 32'h1, rsp);
    pins(2'b00, 1'b0);
    i_ums_modem.set_line(0, 2, 1'b1);
    settle();
    pins(2'b01, 1'b1);
    rd_chk(ums_pkg::OFS_MSR0, 32'h04, ums_pkg::RESP_OKAY);
    pins(2'b00, 1'b1);
    axi_write(ums_pkg::OFS_STAT, 32'h1, rsp);
    pins(2'b00, 1'b0);
    i_ums_modem.set_line(1, 3, 1'b0);
    settle();
    i_ums_modem.set_line(1, 3, 1'b1);
    settle();
    pins(2'b00, 1'b0);
    rd_chk(ums_pkg::OFS_STAT, 32'h0, ums_pkg::RESP_OKAY);
    rd_chk(ums_pkg::OFS_MSR1, 32'h08, ums_pkg::RESP_OKAY);
    axi_write(ums_pkg::OFS_MASK, 32'h00, rsp);
    i_ums_modem.set_line(0, 0, 1'b0);
    settle();
    pins(2'b00, 1'b0);
    axi_write(ums_pkg::OFS_MASK, 32'h01, rsp);
    pins(2'b00, 1'b1);
    i_ums_modem.set_line(0, 0, 1'b1);
    settle();
    rd_chk(ums_pkg::OFS_MSR0, 32'h01, ums_pkg::RESP_OKAY);
    axi_write(ums_pkg::OFS_STAT, 32'h1, rsp);
    pins(2'b00, 1'b0);
    // Port 1 enabled and unmasked on its own
    axi_write(ums_pkg::OFS_IER1, 32'h08, rsp);
    axi_write(ums_pkg::OFS_MASK, 32'h02, rsp);
    i_ums_modem.set_line(1, 1, 1'b0);
    settle();
    pins(2'b00, 1'b1);
    rd_chk(ums_pkg::OFS_STAT, 32'h2, ums_pkg::RESP_OKAY);
    i_ums_modem.set_line(1, 1, 1'b1);
    settle();
    pins(2'b10, 1'b1);
    rd_chk(ums_pkg::OFS_MSR1, 32'h02, ums_pkg::RESP_OKAY);
    axi_write(ums_pkg::OFS_STAT, 32'h2, rsp);
    pins(2'b00, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_lines();
    t_irq();
    finish_test();
  end
endmodule
